// >>> logic/msd_pkg.sv
package msd_pkg;
  // ---------------------------------------------------------------
  // address map: sizes, bases, widths and reset values
  // ---------------------------------------------------------------
  localparam int PC_W = 16;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  localparam int VEC_NUM_W = 5;
  localparam int PROG_BYTES = 32768;
  localparam int PROG_AW = 15;
  localparam logic [7:0] PROG_FILL = 8'hFF;
  localparam int INTERNAL_RAM_BYTES = 256;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam int BANK_REGS = 8;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam logic [7:0] BIT_ADDR_MAX = 8'h7F;
  localparam int EXTENDED_RAM_BYTES = 768;
  localparam int EXTENDED_RAM_AW = 10;
  localparam logic [15:0] DISP_BASE = 16'h0000;
  localparam int DISP_BYTES = 27;
  localparam int SFR_BYTES = 128;

  // data access mode
  typedef enum logic [3:0] {
    MSD_DIRECT = 4'h1,
    MSD_INDIRECT = 4'h2,
    MSD_REGNUM = 4'h4,
    MSD_BIT = 4'h8
  } msd_mode_t;
endpackage : msd_pkg

// >>> logic/msd_decoder.sv
module msd_decoder (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic pc_load, // load program counter (jump)
  input wire logic [15:0] pc_load_val, // jump target
  input wire logic pc_inc, // advance program counter
  input wire logic irq_take, // vector to interrupt
  input wire logic [4:0] irq_num, // interrupt number
  input wire logic prog_we, // program memory write
  input wire logic [15:0] prog_waddr, // program write address
  input wire logic [7:0] prog_wdata, // program write data
  input wire logic data_req, // internal data access
  input wire logic data_we, // write when high
  input wire msd_pkg::msd_mode_t data_mode, // addressing mode
  input wire logic [7:0] data_addr, // byte, register or bit address
  input wire logic [7:0] data_wdata, // write data (bit in lsb)
  input wire logic [7:0] sfr_rdata, // function space read data
  input wire logic [1:0] bank_sel, // status word bank bits
  input wire logic [15:0] data_pointer_reg, // 16-bit data pointer
  input wire logic xr_req, // extended RAM access
  input wire logic xr_we, // extended RAM write
  input wire logic [7:0] xr_wdata, // extended RAM write data
  input wire logic [4:0] disp_addr, // display segment index
  output logic [15:0] pc, // program counter
  output logic [7:0] prog_rdata, // fetched byte
  output logic [7:0] data_rdata, // internal data read
  output logic sfr_sel, // function space access pulse
  output logic sfr_we, // function space write
  output logic [6:0] sfr_addr, // function space offset
  output logic [7:0] sfr_wdata, // function space write data
  output logic [7:0] xr_rdata, // extended RAM read
  output logic xr_miss, // pointer beyond extended RAM
  output logic [7:0] disp_data // display segment byte
);
  logic [7:0] prog_mem [msd_pkg::PROG_BYTES];
  logic [7:0] internal_ram [msd_pkg::INTERNAL_RAM_BYTES];
  logic [7:0] extended_ram [msd_pkg::EXTENDED_RAM_BYTES];

  // ---------------------------------------------------------------
  // program counter
  // ---------------------------------------------------------------
  // vector per source
  wire [15:0] vec_addr = msd_pkg::VEC_BASE + {8'h00, irq_num, 3'h0};
  wire [15:0] next_pc = irq_take ? vec_addr : pc_load ? pc_load_val :
                        pc_inc ? pc + 16'h0001 : pc;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      pc <= msd_pkg::PC_RESET;
    else
      pc <= next_pc;

  // ---------------------------------------------------------------
  // program memory
  // ---------------------------------------------------------------
  // implemented lower half
  wire fetch_hit = (pc[15] == 1'b0);
  wire pw_hit = (prog_waddr[15] == 1'b0);
  always_ff @(posedge sys_clk)
    if (prog_we && pw_hit)
      prog_mem[prog_waddr[14:0]] <= prog_wdata;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      prog_rdata <= msd_pkg::PROG_FILL;
    else
      prog_rdata <= fetch_hit ? prog_mem[pc[14:0]] : msd_pkg::PROG_FILL;

  // ---------------------------------------------------------------
  // internal data decode
  // ---------------------------------------------------------------
  // bank register address
  wire [7:0] reg_addr = {3'h0, bank_sel, data_addr[2:0]};
  // bit area byte and bit index
  wire [7:0] bit_byte = msd_pkg::BIT_BYTE_BASE + {4'h0, data_addr[6:3]};
  wire [2:0] bit_idx = data_addr[2:0];
  wire is_dir = (data_mode == msd_pkg::MSD_DIRECT);
  wire is_bit = (data_mode == msd_pkg::MSD_BIT);
  // direct upper half goes to function space
  wire to_sfr = is_dir && data_addr[7];
  wire [7:0] ram_addr = (data_mode == msd_pkg::MSD_REGNUM) ? reg_addr :
                        is_bit ? bit_byte : data_addr;
  wire [7:0] ram_byte = internal_ram[ram_addr];
  wire [7:0] bit_mask = 8'h01 << bit_idx;
  wire [7:0] ram_new = is_bit ? ((ram_byte & ~bit_mask) |
                                 (data_wdata[0] ? bit_mask : 8'h00)) : data_wdata;
  wire [7:0] ram_rd = is_bit ? {7'h00, ram_byte[bit_idx]} : ram_byte;

  // data space separate from program space
  always_ff @(posedge sys_clk)
    if (data_req && data_we && !to_sfr && !(is_bit && data_addr > msd_pkg::BIT_ADDR_MAX))
      internal_ram[ram_addr] <= ram_new;

  // data read and function space strobe
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      data_rdata <= 8'h00;
      sfr_sel <= 1'b0;
      sfr_we <= 1'b0;
      sfr_addr <= 7'h00;
      sfr_wdata <= 8'h00;
    end
    else
    begin
      data_rdata <= to_sfr ? sfr_rdata : ram_rd;
      sfr_sel <= data_req && to_sfr;
      sfr_we <= data_req && to_sfr && data_we;
      sfr_addr <= data_addr[6:0];
      sfr_wdata <= data_wdata;
    end

  // ---------------------------------------------------------------
  // extended RAM
  // ---------------------------------------------------------------
  // pointer addressing
  wire xr_hit = (data_pointer_reg < 16'(msd_pkg::EXTENDED_RAM_BYTES));
  wire [9:0] xr_idx = data_pointer_reg[9:0];
  wire [9:0] disp_idx = 10'(msd_pkg::DISP_BASE) + {5'h00, disp_addr};
  always_ff @(posedge sys_clk)
    if (xr_req && xr_we && xr_hit)
      extended_ram[xr_idx] <= xr_wdata;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      xr_rdata <= 8'h00;
      xr_miss <= 1'b0;
      disp_data <= 8'h00;
    end
    else
    begin
      xr_rdata <= xr_hit ? extended_ram[xr_idx] : 8'h00;
      xr_miss <= xr_req && !xr_hit;
      disp_data <= (disp_addr < 5'(msd_pkg::DISP_BYTES)) ? extended_ram[disp_idx] : 8'h00;
    end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_pc_vector: assert property (@(posedge sys_clk) disable iff (!nrst)
    irq_take |=> pc == 16'h0003 + 16'({$past(irq_num), 3'h0}))
    else $error("vector address wrong");
  a_vec_spacing: assert property (@(posedge sys_clk) disable iff (!nrst)
    irq_take && irq_num == 5'h01 |=> pc == 16'h000B)
    else $error("vector slot spacing wrong");
  a_pc_step: assert property (@(posedge sys_clk) disable iff (!nrst)
    pc_inc && !pc_load && !irq_take |=> pc == 16'($past(pc) + 16'h0001))
    else $error("pc did not advance");
  a_fill_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    pc[15] |=> prog_rdata == 8'hFF)
    else $error("unimplemented fetch not filled");
  a_sfr_direct: assert property (@(posedge sys_clk) disable iff (!nrst)
    data_req && data_mode == msd_pkg::MSD_DIRECT && data_addr[7] |=> sfr_sel)
    else $error("direct high address missed function space");
  a_upper_indirect: assert property (@(posedge sys_clk) disable iff (!nrst)
    data_req && data_mode == msd_pkg::MSD_INDIRECT |=> !sfr_sel)
    else $error("indirect access reached function space");
  a_xr_range: assert property (@(posedge sys_clk) disable iff (!nrst)
    xr_req && data_pointer_reg >= 16'h0300 |=> xr_miss && xr_rdata == 8'h00)
    else $error("pointer beyond extended RAM not flagged");
  a_reset_pc: assert property (@(posedge sys_clk)
    $rose(nrst) |-> pc == 16'h0000)
    else $error("pc not zero after reset");
endmodule : msd_decoder

// >>> test/msd_sfr_model.sv
// ---------------------------------------------------------------
// function space stand-in for the core side
// ---------------------------------------------------------------
module msd_sfr_model (
  input wire logic sys_clk, // system clock
  input wire logic [7:0] data_addr, // offset of a direct access
  input wire logic sfr_we, // write pulse
  input wire logic [6:0] sfr_addr, // write offset
  input wire logic [7:0] sfr_wdata, // write data
  output logic [7:0] sfr_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [128];
  // answer at once, the decoder samples it at the taking edge
  assign sfr_rdata = regs[data_addr[6:0]];
  // store the decoder's write pulses
  always @(posedge sys_clk)
  begin
    if (sfr_we)
      regs[sfr_addr] <= sfr_wdata;
  end
endmodule : msd_sfr_model

// >>> test/tb_msd_decoder.sv
module tb_msd_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, nrst = 0, pc_load = 0, pc_inc = 0, irq_take = 0, prog_we = 0;
  logic data_req = 0, data_we = 0, xr_req = 0, xr_we = 0, sfr_sel, sfr_we, xr_miss;
  logic [15:0] pc_load_val = '0, prog_waddr = '0, data_pointer_reg = '0, pc;
  logic [4:0] irq_num = '0, disp_addr = '0;
  logic [7:0] prog_wdata = '0, data_addr = '0, data_wdata = '0, xr_wdata = '0, sfr_rdata;
  logic [7:0] prog_rdata, data_rdata, sfr_wdata, xr_rdata, disp_data;
  logic [6:0] sfr_addr;
  logic [1:0] bank_sel = '0;
  msd_pkg::msd_mode_t data_mode = msd_pkg::MSD_DIRECT;
  int mismatches = 0, n_checks = 0;
  msd_decoder msd_decoder_i (.*);
  msd_sfr_model msd_sfr_model_i (.*);
  always #5 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task results;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // one internal data access, returns after the answer lands
  task dat(input msd_pkg::msd_mode_t m, input logic w, input logic [7:0] a, d);
    @(posedge sys_clk);
    data_req <= 1'b1;
    data_we <= w;
    data_mode <= m;
    data_addr <= a;
    data_wdata <= d;
    @(posedge sys_clk);
    data_req <= 1'b0;
    #1;
  endtask : dat
  // one extended ram access through the pointer
  task xr(input logic w, input logic [15:0] p, input logic [7:0] d);
    @(posedge sys_clk);
    xr_req <= 1'b1;
    xr_we <= w;
    data_pointer_reg <= p;
    xr_wdata <= d;
    @(posedge sys_clk);
    xr_req <= 1'b0;
    #1;
  endtask : xr
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_prog;
    @(posedge sys_clk);
    prog_we <= 1'b1;
    prog_waddr <= 16'h000B;
    prog_wdata <= 8'hA5;
    @(posedge sys_clk);
    prog_waddr <= 16'h8000;
    prog_wdata <= 8'h00;
    irq_take <= 1'b1;
    irq_num <= 5'h01;
    @(posedge sys_clk);
    prog_we <= 1'b0;
    irq_take <= 1'b0;
    #1 chk(pc, 16'h000B);
    @(posedge sys_clk);
    pc_load <= 1'b1;
    pc_load_val <= 16'h8000;
    #1 chk(prog_rdata, 8'hA5);
    @(posedge sys_clk);
    pc_load <= 1'b0;
    irq_take <= 1'b1;
    irq_num <= 5'h02;
    #1 chk(pc, 16'h8000);
    @(posedge sys_clk);
    irq_take <= 1'b0;
    #1 chk(prog_rdata, 8'hFF);
    chk(pc, 16'h0013);
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    #1 chk(pc, 16'h0000);
    @(posedge sys_clk);
    pc_inc <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pc_inc <= 1'b0;
    #1 chk(pc, 16'h0002);
  endtask : t_prog
  task t_data;
    dat(msd_pkg::MSD_INDIRECT, 1'b1, 8'h90, 8'h77);
    dat(msd_pkg::MSD_DIRECT, 1'b1, 8'h90, 8'h3C);
    chk({sfr_sel, sfr_we, sfr_addr, sfr_wdata}, {2'h3, 7'h10, 8'h3C});
    dat(msd_pkg::MSD_DIRECT, 1'b0, 8'h90, 8'h00);
    chk(data_rdata, 8'h3C);
    dat(msd_pkg::MSD_INDIRECT, 1'b0, 8'h90, 8'h00);
    chk({sfr_sel, data_rdata}, 9'h077);
    dat(msd_pkg::MSD_DIRECT, 1'b1, 8'h45, 8'hE1);
    dat(msd_pkg::MSD_INDIRECT, 1'b0, 8'h45, 8'h00);
    chk(data_rdata, 8'hE1);
    dat(msd_pkg::MSD_INDIRECT, 1'b1, 8'hFF, 8'h5A);
    dat(msd_pkg::MSD_INDIRECT, 1'b0, 8'hFF, 8'h00);
    chk(data_rdata, 8'h5A);
  endtask : t_data
  task t_bank_bit;
    dat(msd_pkg::MSD_REGNUM, 1'b1, 8'h07, 8'h3E);
    dat(msd_pkg::MSD_INDIRECT, 1'b0, 8'h07, 8'h00);
    chk(data_rdata, 8'h3E);
    @(posedge sys_clk);
    bank_sel <= 2'h2;
    dat(msd_pkg::MSD_REGNUM, 1'b1, 8'h07, 8'hC4);
    dat(msd_pkg::MSD_INDIRECT, 1'b0, 8'h17, 8'h00);
    chk(data_rdata, 8'hC4);
    dat(msd_pkg::MSD_INDIRECT, 1'b1, 8'h21, 8'h00);
    dat(msd_pkg::MSD_BIT, 1'b1, 8'h0A, 8'h01);
    dat(msd_pkg::MSD_BIT, 1'b1, 8'h82, 8'h01);
    dat(msd_pkg::MSD_INDIRECT, 1'b0, 8'h21, 8'h00);
    chk(data_rdata, 8'h04);
  endtask : t_bank_bit
  task t_extended_ram;
    xr(1'b1, 16'h02FF, 8'h6B);
    xr(1'b1, 16'h0045, 8'h5E);
    xr(1'b0, 16'h02FF, 8'h00);
    chk({xr_miss, xr_rdata}, 9'h06B);
    xr(1'b0, 16'h0300, 8'h00);
    chk({xr_miss, xr_rdata}, 9'h100);
    dat(msd_pkg::MSD_INDIRECT, 1'b0, 8'h45, 8'h00);
    chk(data_rdata, 8'hE1);
    xr(1'b1, 16'h001A, 8'h9D);
    @(posedge sys_clk);
    disp_addr <= 5'h1A;
    @(posedge sys_clk);
    #1 chk(disp_data, 8'h9D);
  endtask : t_extended_ram
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    #1 chk(pc, 16'h0000);
    t_prog;
    t_data;
    t_bank_bit;
    t_extended_ram;
    results;
  end
  initial
  begin
    #20000;
    mismatches++;
    results;
  end
endmodule : tb_msd_decoder
